// >>> src/adccc_pkg.sv
// Package for the converter control block: register layout, codes, timing.
// Assumes a single 100 MHz system clock domain.
package adccc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0]  CTRL_OFFSET     = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET   = 4'h4;
    localparam logic [15:0] CTRL_RESET      = 16'h0200;
    localparam int          ACQ_HI          = 9;
    localparam int          ACQ_LO          = 8;
    localparam int          ARM_BIT         = 7;
    localparam int          POWER_BIT       = 5;
    localparam int          MODE_HI         = 4;
    localparam int          MODE_LO         = 3;
    localparam int          TYPE_HI         = 2;
    localparam int          TYPE_LO         = 0;
    localparam logic [15:0] CTRL_WMASK      = 16'h03BF;

    // ------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------
    localparam logic [1:0] ACQ_2   = 2'h0;
    localparam logic [1:0] ACQ_4   = 2'h1;
    localparam logic [1:0] ACQ_8   = 2'h2;
    localparam logic [1:0] ACQ_16  = 2'h3;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_DIFF   = 2'b01,
        MODE_PSEUDO = 2'b10,
        MODE_RSVD   = 2'b11
    } adccc_mode_t;

    typedef enum logic [2:0] {
        TRIG_PIN    = 3'b000,
        TRIG_TIMER2 = 3'b001,
        TRIG_SECOND_GENERAL_TIMER = 3'b010,
        TRIG_SINGLE = 3'b011,
        TRIG_CONT   = 3'b100,
        TRIG_LOGIC  = 3'b101,
        TRIG_RSVD6  = 3'b110,
        TRIG_RSVD7  = 3'b111
    } adccc_trig_t;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int POWERUP_US     = 5;
    localparam int POWERUP_CYCLES = POWERUP_US * CLK_MHZ;

    // Converter-side request bundle
    typedef struct packed {
        logic        start;
        logic        powerOn;
        adccc_mode_t mode;
        logic [4:0]  acqClocks;
    } adccc_conv_t;

endpackage

// >>> src/adccc_sync.sv
// Three-stage synchroniser with agreement filter for an outside pin.
// Assumes the pin is asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module adccc_sync (
    input  wire logic sys_clk,  // System clock
    input  wire logic rst,      // Async reset, high
    input  wire logic clkEn,    // Clock enable
    input  wire logic pinIn,    // Raw pin
    output logic      levelOut  // Filtered level
);
    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic       level_q;
    logic       level_d;

    always_comb begin
        stage_d = {stage_q[1:0], pinIn};
        level_d = level_q;
        // Only the later two stages are compared; stage 0 feeds stage 1 alone
        if (stage_q[1] == stage_q[2]) begin
            level_d = stage_q[2];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage_q <= 3'h0;
            level_q <= 1'b0;
        end else if (clkEn) begin
            stage_q <= stage_d;
            level_q <= level_d;
        end
    end

    assign levelOut = level_q;
endmodule
`default_nettype wire

// >>> src/adccc_top.sv
// Conversion control register and trigger selection for a SAR converter.
// Assumes a register port master on sys_clk and a converter that pulses
// convDone when a conversion ends; timer and logic-array triggers are
// single-cycle pulses on sys_clk.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module adccc_top
    import adccc_pkg::*;
#(
    parameter int POWERUP_CNT = adccc_pkg::POWERUP_CYCLES
) (
    input  wire logic               sys_clk,                          // System clock
    input  wire logic               rst,                              // Async reset, high
    input  wire logic               clkEn,                            // Freezes state when low
    input  wire logic [3:0]         regAddr,                          // Register byte address
    input  wire logic [15:0]        regWdata,                         // Write data
    input  wire logic               regWr,                            // Write strobe
    input  wire logic               regRd,                            // Read strobe
    output logic      [15:0]        regRdata,                         // Read data, next cycle
    input  wire logic               external_convert_pin,             // Start pin, async
    input  wire logic               first_general_timer,              // Timer pulse
    input  wire logic               second_general_timer,             // Timer pulse
    input  wire logic               programmable_logic_array_trigger, // Logic array pulse
    input  wire logic               convDone,                         // Conversion finished
    output adccc_pkg::adccc_conv_t  conv                              // To converter
);
    import adccc_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] acqDecode(input logic [1:0] code);
        case (code)
            ACQ_2:   acqDecode = 5'h02;
            ACQ_4:   acqDecode = 5'h04;
            ACQ_8:   acqDecode = 5'h08;
            ACQ_16:  acqDecode = 5'h10;
            default: acqDecode = 5'h08;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Pin input and edge detect
    // ------------------------------------------------------------
    logic pinLevel;
    logic pinPrev_q;
    logic pinPrev_d;

    adccc_sync u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .pinIn    (external_convert_pin),
        .levelOut (pinLevel)
    );

    assign pinPrev_d = pinLevel;
    wire pinEdge = pinLevel & ~pinPrev_q;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic        busy_q;
    logic        busy_d;
    logic        single_q;
    logic        single_d;
    logic        start_q;
    logic        start_d;
    logic [15:0] pwrCnt_q;
    logic [15:0] pwrCnt_d;
    // Set by a continuous start, so the chain outlives the arm bit
    logic        contRun_q;
    logic        contRun_d;

    adccc_trig_t trig;
    logic        armed;
    logic        powered;
    logic        trigHit;
    logic        contRun;
    logic        pwrReady;

    assign trig     = adccc_trig_t'(ctrl_q[TYPE_HI:TYPE_LO]);
    assign armed    = ctrl_q[ARM_BIT];
    assign powered  = ctrl_q[POWER_BIT];
    assign pwrReady = (pwrCnt_q == 16'h0000);

    always_comb begin
        trigHit = 1'b0;
        case (trig)
            TRIG_PIN:    trigHit = pinEdge;
            TRIG_TIMER2: trigHit = second_general_timer;
            TRIG_SECOND_GENERAL_TIMER: trigHit = first_general_timer;
            TRIG_SINGLE: trigHit = ~single_q;
            TRIG_CONT:   trigHit = 1'b1;
            TRIG_LOGIC:  trigHit = programmable_logic_array_trigger;
            default:     trigHit = 1'b0;
        endcase
    end

    // Continuous mode keeps running even after the arm bit drops
    assign contRun = (trig == TRIG_CONT) & contRun_q;

    always_comb begin
        ctrl_d   = ctrl_q;
        busy_d   = busy_q;
        single_d = single_q;
        start_d  = 1'b0;
        rdata_d  = 16'h0000;
        pwrCnt_d = pwrCnt_q;
        contRun_d = contRun_q;

        if (!powered) begin
            pwrCnt_d = POWERUP_CNT[15:0];
        end else if (!pwrReady) begin
            pwrCnt_d = pwrCnt_q - 16'h0001;
        end

        if (regWr && regAddr == CTRL_OFFSET) begin
            ctrl_d = regWdata & CTRL_WMASK;
            if (regWdata[TYPE_HI:TYPE_LO] != TRIG_SINGLE) begin
                single_d = 1'b0;
            end
        end

        if (convDone) begin
            busy_d = 1'b0;
            if (trig == TRIG_SINGLE && single_q) begin
                // Hardware return wins over a same-cycle software write
                ctrl_d[TYPE_HI:TYPE_LO] = TRIG_PIN;
                single_d                = 1'b0;
            end
        end

        // New starts only when powered and idle, and either armed or in a running continuous chain
        if (powered && !busy_q && !start_q) begin
            if ((armed && trigHit) || (contRun && trigHit)) begin
                start_d = 1'b1;
                busy_d  = 1'b1;
                if (trig == TRIG_SINGLE) begin
                    single_d = 1'b1;
                end
                if (trig == TRIG_CONT) begin
                    contRun_d = 1'b1;
                end
            end
        end else if (!powered) begin
            busy_d = 1'b0;
        end

        // Chain ends once software leaves continuous type or powers down
        if (ctrl_d[TYPE_HI:TYPE_LO] != TRIG_CONT || !ctrl_d[POWER_BIT]) begin
            contRun_d = 1'b0;
        end

        if (regRd) begin
            case (regAddr)
                CTRL_OFFSET:   rdata_d = ctrl_q;
                STATUS_OFFSET: rdata_d = {13'h0000, pwrReady, single_q, busy_q};
                default:       rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q    <= CTRL_RESET;
            rdata_q   <= 16'h0000;
            busy_q    <= 1'b0;
            single_q  <= 1'b0;
            start_q   <= 1'b0;
            pwrCnt_q  <= POWERUP_CNT[15:0];
            contRun_q <= 1'b0;
            pinPrev_q <= 1'b0;
        end else if (clkEn) begin
            ctrl_q    <= ctrl_d;
            rdata_q   <= rdata_d;
            busy_q    <= busy_d;
            single_q  <= single_d;
            start_q   <= start_d;
            pwrCnt_q  <= pwrCnt_d;
            contRun_q <= contRun_d;
            pinPrev_q <= pinPrev_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    adccc_conv_t conv_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            conv_q <= '{start: 1'b0, powerOn: 1'b0, mode: MODE_SINGLE, acqClocks: 5'h08};
        end else if (clkEn) begin
            conv_q.start     <= start_d;
            conv_q.powerOn   <= ctrl_d[POWER_BIT];
            conv_q.mode      <= adccc_mode_t'(ctrl_d[MODE_HI:MODE_LO]);
            conv_q.acqClocks <= acqDecode(ctrl_d[ACQ_HI:ACQ_LO]);
        end
    end

    assign conv     = conv_q;
    assign regRdata = rdata_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_singleEnd;
        (trig == TRIG_SINGLE) && single_q && convDone && clkEn;
    endsequence

    a_single_return: assert property (@(posedge sys_clk) disable iff (rst)
        s_singleEnd |=> (ctrl_q[TYPE_HI:TYPE_LO] == TRIG_PIN))
        else $error("single conversion did not return type to pin");

    a_reserved_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        (trig inside {TRIG_RSVD6, TRIG_RSVD7}) && !busy_q |=> !conv.start)
        else $error("reserved type started a conversion");

    a_unarmed_block: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && !armed && trig != TRIG_CONT |=> !conv.start)
        else $error("start without arm");

    a_power_follow: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn |=> conv.powerOn == ctrl_q[POWER_BIT])
        else $error("power output mismatch");

    a_mode_follow: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn |=> conv.mode == adccc_mode_t'(ctrl_q[MODE_HI:MODE_LO]))
        else $error("mode output mismatch");

    a_acq_two: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl_q[ACQ_HI:ACQ_LO] == ACQ_2 && $stable(ctrl_q) |-> conv.acqClocks == 5'h02)
        else $error("acquisition code 00 not two clocks");

    a_acq_sixteen: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl_q[ACQ_HI:ACQ_LO] == ACQ_16 && $stable(ctrl_q) |-> conv.acqClocks == 5'h10)
        else $error("acquisition code 11 not sixteen clocks");

    a_timer_start: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && armed && powered && trig == TRIG_TIMER2 && second_general_timer
        && !busy_q && !start_q |=> conv.start)
        else $error("second timer did not start conversion");

    a_pin_start: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && armed && powered && trig == TRIG_PIN && pinEdge
        && !busy_q && !start_q |=> conv.start)
        else $error("pin edge did not start conversion");

    sequence s_contIdle;
        contRun_q && !busy_q && !start_q && powered && clkEn;
    endsequence

    a_cont_persist: assert property (@(posedge sys_clk) disable iff (rst)
        s_contIdle |=> conv.start)
        else $error("continuous chain stopped");

    a_busy_block: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && busy_q |=> !conv.start)
        else $error("start while busy");

    a_start_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && conv.start |=> !conv.start)
        else $error("start longer than one cycle");

    a_power_block: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && !powered |=> !conv.start)
        else $error("start while powered down");

    a_first_timer: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && armed && powered && trig == TRIG_SECOND_GENERAL_TIMER && first_general_timer
        && !busy_q && !start_q |=> conv.start)
        else $error("first timer did not start conversion");

    a_logic_start: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && armed && powered && trig == TRIG_LOGIC && programmable_logic_array_trigger
        && !busy_q && !start_q |=> conv.start)
        else $error("logic array did not start conversion");

    a_single_launch: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && armed && powered && trig == TRIG_SINGLE && !single_q
        && !busy_q && !start_q |=> conv.start)
        else $error("single conversion did not start");

    a_pin_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn && trig == TRIG_PIN && !pinEdge |=> !conv.start)
        else $error("pin type started without an edge");

endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the converter control block: register port,
// trigger selection, single and continuous conversions.
// Assumes adccc_pkg is compiled first; the bench stands in for the converter.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adccc_pkg::*;

    // ------------------------------------------------------------
    // Signals and instance
    // ------------------------------------------------------------
    logic                  sys_clk;
    logic                  rst;
    logic                  clkEn;
    logic [3:0]            regAddr;
    logic [15:0]           regWdata;
    logic                  regWr;
    logic                  regRd;
    logic [15:0]           regRdata;
    logic                  extPin;
    logic                  firstTmr;
    logic                  secondTmr;
    logic                  plaTrig;
    logic                  convDone;
    adccc_conv_t           conv;
    int                    fail_count;
    int                    total_checks;
    int                    cycleCount;

    adccc_top #(.POWERUP_CNT(4)) i_dut (
        .sys_clk                          (sys_clk),
        .rst                              (rst),
        .clkEn                            (clkEn),
        .regAddr                          (regAddr),
        .regWdata                         (regWdata),
        .regWr                            (regWr),
        .regRd                            (regRd),
        .regRdata                         (regRdata),
        .external_convert_pin             (extPin),
        .first_general_timer              (firstTmr),
        .second_general_timer             (secondTmr),
        .programmable_logic_array_trigger (plaTrig),
        .convDone                         (convDone),
        .conv                             (conv)
    );

    // ------------------------------------------------------------
    // Clock, timeout, shared tasks
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Whole run needs well under 2000 cycles
    always @(posedge sys_clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 20000) begin
            fail_count = fail_count + 1;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] cfg(input logic arm, input logic pwr, input logic [1:0] md, input logic [2:0] typ);
        return {6'h00, ACQ_8, arm, 1'b0, pwr, md, typ};
    endfunction

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge sys_clk);
        regWr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd   <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic fire(input int src);
        @(posedge sys_clk);
        case (src)
            0:       secondTmr <= 1'b1;
            1:       firstTmr  <= 1'b1;
            default: plaTrig   <= 1'b1;
        endcase
        @(posedge sys_clk);
        secondTmr <= 1'b0;
        firstTmr  <= 1'b0;
        plaTrig   <= 1'b0;
    endtask

    task automatic wait_start(input int n, output logic got);
        got = 1'b0;
        for (int i = 0; i < n; i++) begin
            #1;
            if (conv.start === 1'b1) begin
                got = 1'b1;
                break;
            end
            @(posedge sys_clk);
        end
    endtask

    // Converter answer: one-cycle done pulse; no settle, so a restart is seen
    task automatic finish_conv();
        @(posedge sys_clk);
        convDone <= 1'b1;
        @(posedge sys_clk);
        convDone <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_fields();
        logic [15:0] d;
        rd(CTRL_OFFSET, d);
        check(d, 16'h0200);
        check({11'h000, conv.acqClocks}, 16'h0008);
        for (int a = 0; a < 4; a++) begin
            wr(CTRL_OFFSET, {6'h00, a[1:0], 2'h0, a[0], a[1:0], 3'h0});
            @(posedge sys_clk);
            #1;
            check({11'h000, conv.acqClocks}, 16'h0002 << a);
            check({14'h0000, conv.mode}, {14'h0000, a[1:0]});
            check({15'h0000, conv.powerOn}, {15'h0000, a[0]});
        end
        wr(CTRL_OFFSET, 16'hFFFF);
        rd(CTRL_OFFSET, d);
        check(d, 16'h03BF);
        rd(4'h8, d);
        check(d, 16'h0000);
        wr(CTRL_OFFSET, 16'h0000);
        rd(STATUS_OFFSET, d);
        check(d, 16'h0000);
        wr(CTRL_OFFSET, 16'h0020);
        rd(STATUS_OFFSET, d);
        check(d, 16'h0000);
        repeat (4) @(posedge sys_clk);
        rd(STATUS_OFFSET, d);
        check(d, 16'h0004);
    endtask

    task automatic test_triggers();
        logic   got;
        logic   exp;
        int     types[5] = '{1, 2, 5, 6, 7};
        foreach (types[k]) begin
            for (int src = 0; src < 3; src++) begin
                exp = (types[k] == 1 && src == 0) || (types[k] == 2 && src == 1) || (types[k] == 5 && src == 2);
                wr(CTRL_OFFSET, cfg(1'b1, 1'b1, 2'h0, types[k][2:0]));
                fire(src);
                wait_start(3, got);
                check({15'h0000, got}, {15'h0000, exp});
                if (got) finish_conv();
            end
        end
        wr(CTRL_OFFSET, cfg(1'b0, 1'b1, 2'h0, 3'h1));
        fire(0);
        wait_start(3, got);
        check({15'h0000, got}, 16'h0000);
        wr(CTRL_OFFSET, cfg(1'b1, 1'b0, 2'h0, 3'h1));
        fire(0);
        wait_start(3, got);
        check({15'h0000, got}, 16'h0000);
    endtask

    task automatic test_pin();
        logic got;
        wr(CTRL_OFFSET, cfg(1'b1, 1'b1, 2'h0, 3'h0));
        @(posedge sys_clk);
        extPin <= 1'b1;
        wait_start(12, got);
        check({15'h0000, got}, 16'h0001);
        finish_conv();
        // A level held high is not a fresh edge
        wait_start(12, got);
        check({15'h0000, got}, 16'h0000);
        extPin <= 1'b0;
    endtask

    task automatic test_software();
        logic        got;
        logic [15:0] d;
        wr(CTRL_OFFSET, cfg(1'b1, 1'b1, 2'h1, 3'h3));
        wait_start(4, got);
        check({15'h0000, got}, 16'h0001);
        finish_conv();
        rd(CTRL_OFFSET, d);
        check(d, cfg(1'b1, 1'b1, 2'h1, 3'h0));
        wr(CTRL_OFFSET, cfg(1'b0, 1'b1, 2'h1, 3'h0));
        wr(CTRL_OFFSET, cfg(1'b1, 1'b1, 2'h0, 3'h4));
        wait_start(4, got);
        check({15'h0000, got}, 16'h0001);
        finish_conv();
        wait_start(4, got);
        check({15'h0000, got}, 16'h0001);
        // Disarm while busy: the running chain must carry on
        wr(CTRL_OFFSET, cfg(1'b0, 1'b1, 2'h0, 3'h4));
        finish_conv();
        wait_start(4, got);
        check({15'h0000, got}, 16'h0001);
        wr(CTRL_OFFSET, cfg(1'b0, 1'b0, 2'h0, 3'h0));
        finish_conv();
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        fail_count = 0;
        total_checks = 0;
        cycleCount = 0;
        rst = 1'b1;
        clkEn = 1'b1;
        regAddr = 4'h0;
        regWdata = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
        extPin = 1'b0;
        firstTmr = 1'b0;
        secondTmr = 1'b0;
        plaTrig = 1'b0;
        convDone = 1'b0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        test_fields();
        test_triggers();
        test_pin();
        test_software();
        final_report();
    end
endmodule
`default_nettype wire
